// ---- rtl/cas_pkg.sv ----
// Package: constants and types for the processor address space control block.
// Assumes a single processor clock mclk at 100 MHz.
package cas_pkg;
  localparam int unsigned CAS_GPR_COUNT   = 16;
  localparam int unsigned CAS_WORD_W      = 16;
  localparam int unsigned CAS_NSEG_AW     = 16;
  localparam int unsigned CAS_SEG_AW      = 23;
  localparam int unsigned CAS_VEC_W       = 3;
  localparam logic [15:0] CAS_PSA_BASE    = 16'h0000;
  localparam logic [15:0] CAS_PSA_STRIDE  = 16'h0004;
  localparam logic [15:0] CAS_SP_RESET    = 16'h0000;
  localparam logic [15:0] CAS_FCW_RESET   = 16'h4000;
  localparam int unsigned CAS_FCW_SYS_BIT = 14;
  localparam logic [7:0]  CAS_REFRESH_RST = 8'h40;
  localparam int unsigned CAS_IO_WAITS    = 1;
  localparam int unsigned CAS_IO_CYCLES   = 4;
  localparam logic [2:0]  CAS_VEC_UNIMPL  = 3'h1;
  localparam logic [2:0]  CAS_VEC_PRIV    = 3'h2;
  localparam logic [2:0]  CAS_VEC_IRQ     = 3'h5;

  typedef enum logic [3:0] {
    CAS_ST_INTERNAL  = 4'h0,
    CAS_ST_REFRESH   = 4'h1,
    CAS_ST_IO        = 4'h2,
    CAS_ST_SPECIO    = 4'h3,
    CAS_ST_ACK       = 4'h4,
    CAS_ST_DATA      = 4'h8,
    CAS_ST_STACK     = 4'h9,
    CAS_ST_LATER_IF  = 4'hc,
    CAS_ST_FIRST_IF  = 4'hd
  } cas_status_t;

  typedef enum logic [2:0] {
    CAS_SZ_BYTE, CAS_SZ_WORD, CAS_SZ_LONG, CAS_SZ_QUAD, CAS_SZ_INSTR
  } cas_size_t;

  typedef enum logic [2:0] {
    CAS_OP_NONE, CAS_OP_DATA, CAS_OP_PUSH, CAS_OP_POP,
    CAS_OP_FETCH1, CAS_OP_FETCHN, CAS_OP_IO
  } cas_op_t;
endpackage

// ---- rtl/cas_bus_if.sv ----
// Interface: one bus request from the control core to the cycle generator.
// Assumes both ends on mclk.
`timescale 1ns/1ps
`default_nettype none
interface cas_bus_if;
  logic               req;
  logic               busy;
  cas_pkg::cas_op_t   op;
  logic [22:0]        addr;
  logic               write;
  logic               system;
  modport core (output req, output op, output addr, output write, output system, input busy);
  modport gen  (input req, input op, input addr, input write, input system, output busy);
endinterface
`default_nettype wire

// ---- rtl/cas_cycle_gen.sv ----
// Cycle generator: drives status, space and strobe for each bus cycle.
// Assumes requests from the core on mclk; I/O cycles take a fixed length.
`timescale 1ns/1ps
`default_nettype none
module cas_cycle_gen (
  input  wire logic        mclk,
  input  wire logic        rst,
  cas_bus_if.gen           bus,
  input  wire logic        refresh_due,
  output logic             refresh_done,
  output logic [3:0]       status_q,
  output logic             sys_space_q,
  output logic             code_space_q,
  output logic [22:0]      addr_q,
  output logic             strobe_q,
  output logic             write_q
);
  logic [2:0] cnt_q;

  function automatic logic [3:0] op_status(input cas_pkg::cas_op_t op);
    unique case (op)
      cas_pkg::CAS_OP_DATA:   op_status = cas_pkg::CAS_ST_DATA;
      cas_pkg::CAS_OP_PUSH,
      cas_pkg::CAS_OP_POP:    op_status = cas_pkg::CAS_ST_STACK;
      cas_pkg::CAS_OP_FETCH1: op_status = cas_pkg::CAS_ST_FIRST_IF;
      cas_pkg::CAS_OP_FETCHN: op_status = cas_pkg::CAS_ST_LATER_IF;
      cas_pkg::CAS_OP_IO:     op_status = cas_pkg::CAS_ST_IO;
      default:                op_status = cas_pkg::CAS_ST_INTERNAL;
    endcase
  endfunction

  assign bus.busy     = (cnt_q != 3'h0);
  assign refresh_done = (cnt_q == 3'h0) && !bus.req && refresh_due;

  // Memory cycles 3 cycles long, I/O gets one wait for 4 cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q        <= 3'h0;
      status_q     <= cas_pkg::CAS_ST_INTERNAL;
      sys_space_q  <= 1'b1;
      code_space_q <= 1'b0;
      addr_q       <= 23'h0;
      strobe_q     <= 1'b0;
      write_q      <= 1'b0;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        strobe_q <= 1'b0;
        status_q <= cas_pkg::CAS_ST_INTERNAL;
      end
    end else if (bus.req && bus.op != cas_pkg::CAS_OP_NONE) begin
      status_q     <= op_status(bus.op);
      sys_space_q  <= bus.system;
      code_space_q <= (bus.op == cas_pkg::CAS_OP_FETCH1) ||
                      (bus.op == cas_pkg::CAS_OP_FETCHN);
      addr_q       <= bus.addr;
      strobe_q     <= 1'b1;
      write_q      <= bus.write;
      cnt_q        <= (bus.op == cas_pkg::CAS_OP_IO) ?
                      3'(cas_pkg::CAS_IO_CYCLES) : 3'h3;
    end else if (refresh_due) begin
      status_q     <= cas_pkg::CAS_ST_REFRESH;
      code_space_q <= 1'b0;
      strobe_q     <= 1'b1;
      write_q      <= 1'b0;
      cnt_q        <= 3'h3;
    end
  end

  a_io_four_cycles: assert property (@(posedge mclk) disable iff (rst)
    ($rose(strobe_q) && status_q == cas_pkg::CAS_ST_IO) |-> strobe_q[*4] ##1 !strobe_q)
    else $error("I/O cycle not four cycles");
endmodule
`default_nettype wire

// ---- rtl/cas_ctrl.sv ----
// Address space control core: registers, modes, stack, traps and vectoring.
// Assumes a decoder outside presents one operation per request with a handshake.
`timescale 1ns/1ps
`default_nettype none
module cas_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        segmented,
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic [2:0]  op_kind,
  input  wire logic [2:0]  op_size,
  input  wire logic [22:0] op_addr,
  input  wire logic        op_write,
  input  wire logic        op_priv,
  input  wire logic        op_unimpl,
  input  wire logic        op_return,
  input  wire logic [3:0]  op_reg,
  input  wire logic [15:0] op_wdata,
  input  wire logic [3:0]  op_bit,
  input  wire logic        irq_pin,
  input  wire logic [15:0] mem_rdata,
  input  wire logic [7:0]  refresh_rate,
  input  wire logic        refresh_load,
  output logic [3:0]       bus_status_lines,
  output logic             sys_space_q,
  output logic             code_space_q,
  output logic [22:0]      addr_q,
  output logic             strobe_q,
  output logic             write_q,
  output logic [7:0]       lane_data_q,
  output logic             lane_hi_q,
  output logic             bit_value_q,
  output logic [15:0]      rd_data_q,
  output logic             system_mode_q,
  output logic [15:0]      pc_q,
  output logic [15:0]      sp_q,
  output logic             trap_q,
  output logic             size_err_q
);
  typedef enum logic [2:0] {
    CAS_S_IDLE, CAS_S_ACCESS, CAS_S_PUSH_PC, CAS_S_PUSH_FCW,
    CAS_S_LOAD_FCW, CAS_S_LOAD_PC, CAS_S_POP_FCW, CAS_S_POP_PC
  } cas_state_t;

  cas_state_t  state_q;
  logic [15:0] gpr_q [cas_pkg::CAS_GPR_COUNT];
  logic [15:0] fcw_q;
  logic [2:0]  vec_q;
  logic [7:0]  ref_rate_q;
  logic [7:0]  ref_cnt_q;
  logic        ref_due_q;
  logic        refresh_done;
  logic        irq_s1_q;
  logic        irq_s2_q;
  logic [15:0] sp_d;
  logic [22:0] eff_addr;
  logic        irq_take;
  logic        trap_take;
  logic        accept;
  logic        issued_q;
  logic        seq_done;
  logic [15:0] mem_cap_q;

  cas_bus_if bus ();

  cas_cycle_gen u_gen (
    .mclk         (mclk),
    .rst          (rst),
    .bus          (bus.gen),
    .refresh_due  (ref_due_q),
    .refresh_done (refresh_done),
    .status_q     (bus_status_lines),
    .sys_space_q  (sys_space_q),
    .code_space_q (code_space_q),
    .addr_q       (addr_q),
    .strobe_q     (strobe_q),
    .write_q      (write_q)
  );

  // Word, long and instruction accesses drop address bit zero
  function automatic logic [22:0] align(input logic [22:0] a, input logic [2:0] sz, input logic seg);
    logic [22:0] r;
    r = seg ? a : {7'h0, a[15:0]};
    if (sz != 3'(cas_pkg::CAS_SZ_BYTE))
      r[0] = 1'b0;
    align = r;
  endfunction

  function automatic logic [22:0] psa_addr(input logic [2:0] v, input logic [15:0] off);
    psa_addr = {7'h0, cas_pkg::CAS_PSA_BASE + 16'(v) * cas_pkg::CAS_PSA_STRIDE + off};
  endfunction

  assign eff_addr  = align(op_addr, op_size, segmented);
  assign irq_take  = irq_s2_q && state_q == CAS_S_IDLE && !bus.busy;
  assign trap_take = op_valid && (op_unimpl || (op_priv && !fcw_q[cas_pkg::CAS_FCW_SYS_BIT]));
  assign accept    = state_q == CAS_S_IDLE && !bus.busy && !irq_s2_q;
  assign op_ready  = accept;
  assign system_mode_q = fcw_q[cas_pkg::CAS_FCW_SYS_BIT];
  assign sp_q      = sp_d;
  assign sp_d      = gpr_q[15];
  assign pc_q      = gpr_q[14];
  assign seq_done  = issued_q && !bus.busy;

  // Sequence step: one bus cycle issued, then waited for
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      issued_q <= 1'b0;
    end else if (state_q != CAS_S_IDLE && state_q != CAS_S_ACCESS) begin
      if (!issued_q && !bus.busy)
        issued_q <= 1'b1;
      else if (seq_done)
        issued_q <= 1'b0;
    end else begin
      issued_q <= 1'b0;
    end
  end

  // Read word captured each cycle while strobe stands outside refresh cycles, held once released since bus shows junk then
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_cap_q <= 16'h0000;
    end else if (strobe_q && bus_status_lines != cas_pkg::CAS_ST_REFRESH) begin
      mem_cap_q <= mem_rdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_pin;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Refresh interval counter, software loaded rate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_rate_q <= cas_pkg::CAS_REFRESH_RST;
      ref_cnt_q  <= cas_pkg::CAS_REFRESH_RST;
      ref_due_q  <= 1'b0;
    end else begin
      if (refresh_load && fcw_q[cas_pkg::CAS_FCW_SYS_BIT])
        ref_rate_q <= refresh_rate;
      if (ref_cnt_q == 8'h00) begin
        ref_cnt_q <= ref_rate_q;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q - 8'h01;
        if (refresh_done)
          ref_due_q <= 1'b0;
      end
    end
  end

  // Request to the cycle generator
  always_comb begin
    bus.req    = 1'b0;
    bus.op     = cas_pkg::CAS_OP_NONE;
    bus.addr   = 23'h0;
    bus.write  = 1'b0;
    bus.system = fcw_q[cas_pkg::CAS_FCW_SYS_BIT];
    unique case (state_q)
      CAS_S_IDLE: begin
        if (accept && op_valid && !trap_take && op_size != 3'(cas_pkg::CAS_SZ_QUAD)) begin
          bus.req   = op_kind != 3'(cas_pkg::CAS_OP_NONE);
          bus.op    = cas_pkg::cas_op_t'(op_kind);
          bus.write = op_write;
          if (op_kind == 3'(cas_pkg::CAS_OP_PUSH))
            bus.addr = align({7'h0, sp_d - 16'h0002}, cas_pkg::CAS_SZ_WORD, 1'b0);
          else if (op_kind == 3'(cas_pkg::CAS_OP_POP))
            bus.addr = {7'h0, sp_d};
          else if (op_kind == 3'(cas_pkg::CAS_OP_IO))
            bus.addr = {7'h0, op_addr[15:0]};
          else
            bus.addr = eff_addr;
        end
      end
      CAS_S_ACCESS: ;
      CAS_S_PUSH_PC, CAS_S_PUSH_FCW: begin
        bus.req    = !issued_q;
        bus.op     = cas_pkg::CAS_OP_PUSH;
        bus.write  = 1'b1;
        bus.system = 1'b1;
        bus.addr   = {7'h0, sp_d - 16'h0002};
      end
      CAS_S_LOAD_FCW, CAS_S_LOAD_PC: begin
        bus.req    = !issued_q;
        bus.op     = cas_pkg::CAS_OP_DATA;
        bus.system = 1'b1;
        bus.addr   = psa_addr(vec_q, state_q == CAS_S_LOAD_PC ? 16'h0002 : 16'h0000);
      end
      CAS_S_POP_FCW, CAS_S_POP_PC: begin
        bus.req    = !issued_q;
        bus.op     = cas_pkg::CAS_OP_POP;
        bus.system = 1'b1;
        bus.addr   = {7'h0, sp_d};
      end
      default: ;
    endcase
  end

  // Sequencer for entry, return and plain accesses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q    <= CAS_S_IDLE;
      vec_q      <= 3'h0;
      trap_q     <= 1'b0;
      size_err_q <= 1'b0;
    end else begin
      trap_q     <= 1'b0;
      size_err_q <= 1'b0;
      unique case (state_q)
        CAS_S_IDLE: begin
          if (irq_take) begin
            vec_q   <= cas_pkg::CAS_VEC_IRQ;
            state_q <= CAS_S_PUSH_PC;
          end else if (accept && op_valid) begin
            if (op_unimpl) begin
              vec_q   <= cas_pkg::CAS_VEC_UNIMPL;
              trap_q  <= 1'b1;
              state_q <= CAS_S_PUSH_PC;
            end else if (trap_take) begin
              vec_q   <= cas_pkg::CAS_VEC_PRIV;
              trap_q  <= 1'b1;
              state_q <= CAS_S_PUSH_PC;
            end else if (op_size == 3'(cas_pkg::CAS_SZ_QUAD)) begin
              size_err_q <= 1'b1;
            end else if (op_return) begin
              state_q <= CAS_S_POP_FCW;
            end else if (bus.req) begin
              state_q <= CAS_S_ACCESS;
            end
          end
        end
        CAS_S_ACCESS:   if (!bus.busy) state_q <= CAS_S_IDLE;
        CAS_S_PUSH_PC:  if (seq_done) state_q <= CAS_S_PUSH_FCW;
        CAS_S_PUSH_FCW: if (seq_done) state_q <= CAS_S_LOAD_FCW;
        CAS_S_LOAD_FCW: if (seq_done) state_q <= CAS_S_LOAD_PC;
        CAS_S_LOAD_PC:  if (seq_done) state_q <= CAS_S_IDLE;
        CAS_S_POP_FCW:  if (seq_done) state_q <= CAS_S_POP_PC;
        CAS_S_POP_PC:   if (seq_done) state_q <= CAS_S_IDLE;
      endcase
    end
  end

  // Control word: entry sets system mode, loads and pops restore it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fcw_q <= cas_pkg::CAS_FCW_RESET;
    end else if (state_q == CAS_S_PUSH_PC && !bus.busy && bus.req) begin
      fcw_q[cas_pkg::CAS_FCW_SYS_BIT] <= 1'b1;
    end else if ((state_q == CAS_S_LOAD_FCW || state_q == CAS_S_POP_FCW) && seq_done) begin
      fcw_q <= mem_cap_q;
    end
  end

  // Register file; r15 is stack pointer, r14 holds program counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cas_pkg::CAS_GPR_COUNT; i++)
        gpr_q[i] <= 16'h0000;
      gpr_q[15] <= cas_pkg::CAS_SP_RESET;
    end else begin
      if (accept && op_valid && !trap_take && op_kind == 3'(cas_pkg::CAS_OP_NONE) && op_write)
        gpr_q[op_reg] <= op_wdata;
      if (bus.req && !bus.busy && bus.op == cas_pkg::CAS_OP_PUSH)
        gpr_q[15] <= sp_d - 16'h0002;
      if (bus.req && !bus.busy && bus.op == cas_pkg::CAS_OP_POP)
        gpr_q[15] <= sp_d + 16'h0002;
      if ((state_q == CAS_S_LOAD_PC || state_q == CAS_S_POP_PC) && seq_done)
        gpr_q[14] <= mem_cap_q;
    end
  end

  // Read data, byte lane and bit extraction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_q   <= 16'h0000;
      lane_data_q <= 8'h00;
      lane_hi_q   <= 1'b0;
      bit_value_q <= 1'b0;
    end else if (state_q == CAS_S_ACCESS && !bus.busy) begin
      rd_data_q <= mem_cap_q;
      // Even byte is the high-order byte
      lane_hi_q   <= !addr_q[0];
      lane_data_q <= addr_q[0] ? mem_cap_q[7:0] : mem_cap_q[15:8];
      if (op_size == 3'(cas_pkg::CAS_SZ_BYTE))
        bit_value_q <= mem_cap_q[{!addr_q[0], op_bit[2:0]}];
      else
        bit_value_q <= mem_cap_q[op_bit];
    end
  end

  a_entry_system: assert property (@(posedge mclk) disable iff (rst)
    (state_q == CAS_S_PUSH_FCW && $past(state_q) == CAS_S_PUSH_PC) |-> system_mode_q)
    else $error("Entry did not set system mode");
  a_priv_trap: assert property (@(posedge mclk) disable iff (rst)
    (accept && op_valid && op_priv && !op_unimpl && !system_mode_q) |=> trap_q && vec_q == cas_pkg::CAS_VEC_PRIV)
    else $error("Privileged op in normal mode not trapped");
  a_unimpl_trap: assert property (@(posedge mclk) disable iff (rst)
    (accept && op_valid && op_unimpl) |=> trap_q && state_q == CAS_S_PUSH_PC)
    else $error("Unimplemented op not trapped");
  a_word_even: assert property (@(posedge mclk) disable iff (rst)
    ($rose(strobe_q) && bus_status_lines inside {cas_pkg::CAS_ST_FIRST_IF, cas_pkg::CAS_ST_LATER_IF,
     cas_pkg::CAS_ST_STACK}) |-> !addr_q[0])
    else $error("Word access at odd address");
  a_push_down: assert property (@(posedge mclk) disable iff (rst)
    (bus.req && !bus.busy && bus.op == cas_pkg::CAS_OP_PUSH) |=> sp_q == $past(sp_q) - 16'h0002 && addr_q[15:0] == sp_q)
    else $error("Push did not predecrement stack pointer");
  a_quad_refused: assert property (@(posedge mclk) disable iff (rst)
    (accept && op_valid && !trap_take && op_size == 3'(cas_pkg::CAS_SZ_QUAD)) |=>
     size_err_q && !(strobe_q && bus_status_lines != cas_pkg::CAS_ST_REFRESH))
    else $error("Quad access reached memory");
  a_code_space: assert property (@(posedge mclk) disable iff (rst)
    $rose(strobe_q) |-> code_space_q == (bus_status_lines inside {cas_pkg::CAS_ST_FIRST_IF, cas_pkg::CAS_ST_LATER_IF}))
    else $error("Code space tag mismatch");
  a_nseg_range: assert property (@(posedge mclk) disable iff (rst)
    (!segmented && $rose(strobe_q) && bus_status_lines != cas_pkg::CAS_ST_REFRESH) |->
     addr_q[22:16] == 7'h0)
    else $error("Nonsegmented address exceeds 64K");
endmodule
`default_nettype wire

// ---- verification/cas_mem_model.sv ----
// Memory model: answers each bus cycle with a fixed word pattern.
// Assumes cycles from cas_ctrl on mclk; writes are taken and dropped.
`timescale 1ns/1ps
`default_nettype none
module cas_mem_model (
  input  wire logic        mclk,
  input  wire logic        strobe_q,
  input  wire logic [22:0] addr_q,
  output logic [15:0]      mem_rdata
);
  logic [15:0] last_q;

  // Low area holds status blocks: even word fcw, odd word handler
  function automatic logic [15:0] word_at(input logic [22:0] ab);
    logic [22:0] a;
    a = {ab[22:1], 1'b0};
    if (a < 23'h20) begin
      return a[1] ? {5'h00, a[4:2], 8'h00} : 16'h4000;
    end
    return {a[7:0], ~a[7:0]};
  endfunction

  initial last_q = 16'h0000;
  always @(posedge mclk) begin
    if (strobe_q) begin
      last_q <= word_at(addr_q);
    end
  end
  // Released bus shows a changed value, never the last one
  assign mem_rdata = strobe_q ? word_at(addr_q) : ~last_q;
endmodule
`default_nettype wire

// ---- verification/cas_ctrl_test.sv ----
// Testbench for cas_ctrl: hand-written scenarios against a memory model.
// Assumes a 100 MHz mclk and active-high asynchronous rst.
`timescale 1ns/1ps
`default_nettype none
module cas_ctrl_test;
  logic        mclk = 0, rst = 1, segmented = 0, op_valid = 0, op_write = 0;
  logic        op_priv = 0, op_unimpl = 0, op_return = 0, irq_pin = 0, refresh_load = 0;
  logic [2:0]  op_kind = 0, op_size = 0;
  logic [22:0] op_addr = 0;
  logic [3:0]  op_reg = 0, op_bit = 0;
  logic [15:0] op_wdata = 0;
  logic [7:0]  refresh_rate = 8'h40;
  wire logic        op_ready, sys_s, code_s, strobe, write, lane_hi, bitv, sysm, trap, serr;
  wire logic [3:0]  status;
  wire logic [22:0] addr;
  wire logic [7:0]  lane;
  wire logic [15:0] rd, pc, sp, mem_rdata;
  logic [3:0]  m_st;
  logic [22:0] m_addr;
  logic        m_sys, m_code, stb_d = 0, trap_seen = 0, serr_seen = 0, ref_seen = 0;
  int          m_len = 0, rises = 0, cyc = 0, err_total = 0, samples_checked = 0;

  always #5 mclk = ~mclk;

  cas_ctrl dut_u (.mclk(mclk), .rst(rst), .segmented(segmented), .op_valid(op_valid),
    .op_ready(op_ready), .op_kind(op_kind), .op_size(op_size), .op_addr(op_addr),
    .op_write(op_write), .op_priv(op_priv), .op_unimpl(op_unimpl), .op_return(op_return),
    .op_reg(op_reg), .op_wdata(op_wdata), .op_bit(op_bit), .irq_pin(irq_pin),
    .mem_rdata(mem_rdata), .refresh_rate(refresh_rate), .refresh_load(refresh_load),
    .bus_status_lines(status), .sys_space_q(sys_s), .code_space_q(code_s), .addr_q(addr),
    .strobe_q(strobe), .write_q(write), .lane_data_q(lane), .lane_hi_q(lane_hi),
    .bit_value_q(bitv), .rd_data_q(rd), .system_mode_q(sysm), .pc_q(pc), .sp_q(sp),
    .trap_q(trap), .size_err_q(serr));

  cas_mem_model mem_u (.mclk(mclk), .strobe_q(strobe), .addr_q(addr), .mem_rdata(mem_rdata));

  // Bus monitor: refresh cycles are left out of the captures
  always @(posedge mclk) begin
    if (strobe === 1'b1 && status !== 4'h1) begin
      if (stb_d !== 1'b1) begin
        m_st <= status;
        m_addr <= addr;
        m_sys <= sys_s;
        m_code <= code_s;
        rises <= rises + 1;
      end
      m_len <= (stb_d !== 1'b1) ? 1 : m_len + 1;
    end
    stb_d <= strobe;
    if (trap === 1'b1) trap_seen <= 1;
    if (serr === 1'b1) serr_seen <= 1;
    if (status === 4'h1) ref_seen <= 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (op_ready !== 1'b1 && n < lim);
    if (n >= lim) chk(0, 1, "op_ready never came");
  endtask

  task automatic do_op(input logic [2:0] k, input logic [2:0] s, input logic [22:0] a,
                       input logic pr, input logic un, input logic rt, input logic [3:0] b);
    @(posedge mclk);
    #1;
    {op_kind, op_size, op_addr, op_priv, op_unimpl, op_return, op_bit} = {k, s, a, pr, un, rt, b};
    op_write = 0;
    trap_seen = 0;
    serr_seen = 0;
    op_valid = 1;
    wait_ready(50);
    @(posedge mclk);
    #1;
    {op_valid, op_priv, op_unimpl, op_return} = 4'h0;
    wait_ready(300);
    @(posedge mclk);
    #1;
  endtask

  task automatic set_reg(input logic [3:0] r, input logic [15:0] d);
    op_reg = r;
    op_wdata = d;
    @(posedge mclk);
    #1 op_write = 1;
    op_kind = 3'h0;
    op_valid = 1;
    wait_ready(50);
    @(posedge mclk);
    #1 op_valid = 0;
    op_write = 0;
    wait_ready(50);
  endtask

  task automatic t_reset();
    chk(sysm, 1, "fcw mode at reset");
    chk(sp, 0, "sp at reset");
    chk(status, 0, "status at reset");
    chk(strobe, 0, "strobe at reset");
  endtask

  task automatic t_status();
    logic [2:0]  k [6] = '{3'h1, 3'h4, 3'h5, 3'h2, 3'h3, 3'h6};
    logic [2:0]  s [6] = '{3'h1, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1};
    logic [22:0] a [6] = '{23'h41, 23'h43, 23'h45, 23'h0, 23'h0, 23'h10};
    logic [22:0] ea [6] = '{23'h40, 23'h42, 23'h44, 23'hfffe, 23'hfffe, 23'h10};
    logic [3:0]  es [6] = '{4'h8, 4'hd, 4'hc, 4'h9, 4'h9, 4'h2};
    logic [15:0] esp [6] = '{16'h0, 16'h0, 16'h0, 16'hfffe, 16'h0, 16'h0};
    for (int i = 0; i < 6; i++) begin
      do_op(k[i], s[i], a[i], 0, 0, 0, 0);
      chk(m_st, es[i], "status code");
      chk(m_addr, ea[i], "cycle address");
      chk(m_sys, 1, "system space");
      if (k[i] != 3'h6) chk(m_code, (k[i] == 3'h4 || k[i] == 3'h5), "code space");
      chk(m_len, (k[i] == 3'h6) ? 4 : 3, "strobe length");
      chk(sp, esp[i], "stack pointer");
    end
  endtask

  task automatic t_endian();
    do_op(3'h1, 3'h1, 23'h40, 0, 0, 0, 0);
    chk(rd, 16'h40bf, "word read");
    do_op(3'h1, 3'h0, 23'h40, 0, 0, 0, 0);
    chk({lane_hi, lane}, 9'h140, "even byte lane");
    do_op(3'h1, 3'h0, 23'h41, 0, 0, 0, 4'h6);
    chk({lane_hi, lane}, 9'h0bf, "odd byte lane");
    chk(bitv, 0, "byte bit six");
    do_op(3'h1, 3'h1, 23'h40, 0, 0, 0, 4'he);
    chk(bitv, 1, "word bit fourteen");
    do_op(3'h1, 3'h2, 23'h44, 0, 0, 0, 0);
    chk(m_addr[0], 0, "long word even");
  endtask

  task automatic t_quad();
    int r0;
    r0 = rises;
    do_op(3'h1, 3'h3, 23'h40, 0, 0, 0, 0);
    chk(serr_seen, 1, "quad refused");
    chk(rises - r0, 0, "quad bus cycles");
  endtask

  task automatic t_seg();
    segmented = 1;
    do_op(3'h1, 3'h1, 23'h7ffffe, 0, 0, 0, 0);
    chk(m_addr, 23'h7ffffe, "segmented top");
    segmented = 0;
    do_op(3'h1, 3'h1, 23'h7f0042, 0, 0, 0, 0);
    chk(m_addr, 23'h0042, "plain address");
  endtask

  task automatic t_traps();
    set_reg(4'he, 16'h1234);
    chk(pc, 16'h1234, "r14 write");
    set_reg(4'hf, 16'h0100);
    chk(sp, 16'h0100, "r15 write");
    do_op(3'h0, 3'h0, 0, 0, 1, 0, 0);
    chk(trap_seen, 1, "unimplemented trap");
    chk({pc, sp}, {16'h0100, 16'h00fc}, "trap entry");
    chk(sysm, 1, "mode after trap");
    set_reg(4'hf, 16'h0080);
    do_op(3'h0, 3'h0, 0, 0, 0, 1, 0);
    chk({pc, sp}, {16'h827d, 16'h0084}, "return");
    chk(sysm, 0, "mode after return");
    do_op(3'h1, 3'h1, 23'h40, 0, 0, 0, 0);
    chk(m_sys, 0, "normal space");
    do_op(3'h0, 3'h0, 0, 1, 0, 0, 0);
    chk(trap_seen, 1, "privileged trap");
    chk({pc, sysm}, {16'h0200, 1'b1}, "privileged entry");
  endtask

  task automatic t_irq_refresh();
    int n;
    @(posedge mclk);
    #1 irq_pin = 1;
    n = 0;
    while (pc !== 16'h0500 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    #1 irq_pin = 0;
    chk(pc, 16'h0500, "interrupt entry");
    wait_ready(300);
    @(posedge mclk);
    #1 refresh_rate = 8'h04;
    refresh_load = 1;
    ref_seen = 0;
    @(posedge mclk);
    #1 refresh_load = 0;
    repeat (600) @(posedge mclk);
    chk(ref_seen, 1, "refresh cycle");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    t_reset();
    t_status();
    t_endian();
    t_quad();
    t_seg();
    t_traps();
    t_irq_refresh();
    summarize();
  end
endmodule
`default_nettype wire
